/* File: core/phy_ctrl_pkg.sv */
// Package for the PHY control word: register map, field positions, reset values.
// Assumes a 32-bit Avalon-MM register bus with byte addresses.
package phy_ctrl_pkg;
  localparam logic [7:0]  PHY_CONTROL_ADDR = 8'h40;
  localparam logic [7:0]  IRQ_STATUS_ADDR  = 8'h44;
  localparam logic [7:0]  IRQ_ENABLE_ADDR  = 8'h48;
  localparam logic [7:0]  IRQ_CLEAR_ADDR   = 8'h4C;
  localparam logic [7:0]  LINE_STATE_ADDR  = 8'h50;
  localparam logic [7:0]  SUSPEND_ADDR     = 8'h54;
  localparam int          PD_DIS_BIT       = 18;
  localparam int          RST_CAUSE_BIT    = 13;
  localparam int          RES_CAUSE_BIT    = 12;
  localparam int          FILT_LSB         = 8;
  localparam int          FILT_W           = 4;
  localparam int          SUSP_EN_BIT      = 7;
  localparam int          CONF_LSB         = 4;
  localparam int          CONF_W           = 3;
  localparam logic [31:0] PHY_CONTROL_RST  = 32'h0000_0000;
  localparam logic [31:0] PHY_CONTROL_WMASK = 32'h0004_3FF0;
  localparam int          IRQ_W            = 3;
  localparam int          IRQ_RST_CAUSE    = 0;
  localparam int          IRQ_RES_CAUSE    = 1;
  localparam int          IRQ_LINE_CHG     = 2;
  localparam logic [1:0]  LS_SE0           = 2'h0;
  localparam logic [1:0]  LS_J             = 2'h1;
  localparam logic [1:0]  LS_K             = 2'h2;
  localparam int          CNT_W            = 16;
endpackage

/* File: core/line_filter.sv */
// Line-state filter: passes a raw state only after it is stable for 2**shift clocks.
// Assumes the raw line state is already synchronised to core_clk.
`timescale 1ns/1ns
module line_filter #(
  parameter int CNT_W = phy_ctrl_pkg::CNT_W
) (
  input  wire logic       core_clk,
  input  wire logic       rstn,
  input  wire logic [1:0] raw_state,
  input  wire logic [3:0] shift,
  output logic      [1:0] filt_state,
  output logic            filt_change
);
  logic [1:0]       cand_ff;
  logic [1:0]       filt_ff;
  logic [CNT_W:0]   cnt_ff;
  logic             chg_ff;
  logic [1:0]       nxt_cand;
  logic [1:0]       nxt_filt;
  logic [CNT_W:0]   nxt_cnt;
  logic             nxt_chg;
  logic [CNT_W:0]   target;

  always_comb begin
    target   = (CNT_W + 1)'(1) << shift;
    nxt_cand = raw_state;
    nxt_filt = filt_ff;
    nxt_cnt  = cnt_ff;
    nxt_chg  = 1'b0;
    if (raw_state != cand_ff) begin
      nxt_cnt = '0;
    end else if (cand_ff != filt_ff) begin
      if (cnt_ff + (CNT_W + 1)'(1) >= target) begin
        nxt_filt = cand_ff;
        nxt_chg  = 1'b1;
        nxt_cnt  = '0;
      end else begin
        nxt_cnt = cnt_ff + (CNT_W + 1)'(1);
      end
    end else begin
      nxt_cnt = '0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      // Reset to the idle J level of the synchroniser, so no false change follows reset.
      cand_ff <= phy_ctrl_pkg::LS_J;
      filt_ff <= phy_ctrl_pkg::LS_J;
      cnt_ff  <= '0;
      chg_ff  <= 1'b0;
    end else begin
      cand_ff <= nxt_cand;
      filt_ff <= nxt_filt;
      cnt_ff  <= nxt_cnt;
      chg_ff  <= nxt_chg;
    end
  end

  assign filt_state  = filt_ff;
  assign filt_change = chg_ff;
endmodule

/* File: core/usb_phy_control_resume.sv */
// PHY control word, line-state filter and automatic resume cause capture.
// Assumes an Avalon-MM master on core_clk and asynchronous PHY line-state pins.
//
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/1ns
module usb_phy_control_resume (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [1:0]  phy_line_state,
  input  wire logic        phy_suspended,
  output logic             wide_port_a_pd_en,
  output logic             wide_port_b_pd_en,
  output logic      [2:0]  phy_strap_inputs,
  output logic             auto_resume,
  output logic             irq
);
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ACK  = 2'b01
  } bus_state_t;

  bus_state_t  bus_ff;
  bus_state_t  nxt_bus;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic [31:0] ctrl_ff;
  logic [31:0] nxt_ctrl;
  logic [2:0]  sts_ff;
  logic [2:0]  nxt_sts;
  logic [2:0]  ien_ff;
  logic [2:0]  nxt_ien;
  logic        irq_ff;
  logic        nxt_irq;
  logic        pd_ff;
  logic        nxt_pd;
  logic        wait_ff;
  logic        nxt_wait;
  logic [2:0]  strap_ff;
  logic [2:0]  nxt_strap;
  logic        resume_ff;
  logic        nxt_resume;
  logic        susp_ff;
  logic        nxt_susp;
  logic [1:0]  ls_meta_ff;
  logic [1:0]  ls_sync_ff;
  logic        sp_meta_ff;
  logic        sp_sync_ff;
  logic [1:0]  filt_state;
  logic        filt_change;
  logic        wr_hit;
  logic        rd_hit;
  logic        resume_se0;
  logic        resume_k;

  line_filter #(
    .CNT_W (phy_ctrl_pkg::CNT_W)
  ) u_filter (
    .core_clk    (core_clk),
    .rstn        (rstn),
    .raw_state   (ls_sync_ff),
    .shift       (ctrl_ff[phy_ctrl_pkg::FILT_LSB +: phy_ctrl_pkg::FILT_W]),
    .filt_state  (filt_state),
    .filt_change (filt_change)
  );

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  be);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Pins from the PHY pass two flops before any use.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ls_meta_ff <= phy_ctrl_pkg::LS_J;
      ls_sync_ff <= phy_ctrl_pkg::LS_J;
      sp_meta_ff <= 1'b0;
      sp_sync_ff <= 1'b0;
    end else begin
      ls_meta_ff <= phy_line_state;
      ls_sync_ff <= ls_meta_ff;
      sp_meta_ff <= phy_suspended;
      sp_sync_ff <= sp_meta_ff;
    end
  end

  // One wait state keeps read data registered; the answer comes one edge after the request.
  always_comb begin
    nxt_bus   = bus_ff;
    nxt_rdata = rdata_ff;
    wr_hit    = 1'b0;
    rd_hit    = 1'b0;
    case (bus_ff)
      BUS_IDLE: begin
        if (avs_read || avs_write) begin
          nxt_bus = BUS_ACK;
          rd_hit  = avs_read;
        end
      end
      BUS_ACK: begin
        nxt_bus = BUS_IDLE;
        wr_hit  = avs_write;
      end
      default: begin
        nxt_bus = BUS_IDLE;
      end
    endcase
    // Waitrequest is registered so the port comes straight from a flop.
    nxt_wait = (nxt_bus == BUS_IDLE);
    if (rd_hit) begin
      if (avs_address == phy_ctrl_pkg::PHY_CONTROL_ADDR) begin
        nxt_rdata = ctrl_ff;
      end else if (avs_address == phy_ctrl_pkg::IRQ_STATUS_ADDR) begin
        nxt_rdata = {29'h0000_0000, sts_ff};
      end else if (avs_address == phy_ctrl_pkg::IRQ_ENABLE_ADDR) begin
        nxt_rdata = {29'h0000_0000, ien_ff};
      end else if (avs_address == phy_ctrl_pkg::LINE_STATE_ADDR) begin
        nxt_rdata = {28'h000_0000, ls_sync_ff, filt_state};
      end else if (avs_address == phy_ctrl_pkg::SUSPEND_ADDR) begin
        nxt_rdata = {30'h0000_0000, resume_ff, susp_ff};
      end else begin
        nxt_rdata = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      bus_ff   <= BUS_IDLE;
      rdata_ff <= 32'h0000_0000;
      wait_ff  <= 1'b1;
    end else begin
      bus_ff   <= nxt_bus;
      rdata_ff <= nxt_rdata;
      wait_ff  <= nxt_wait;
    end
  end

  always_comb begin
    nxt_ctrl   = ctrl_ff;
    nxt_sts    = sts_ff;
    nxt_ien    = ien_ff;
    nxt_susp   = sp_sync_ff;
    nxt_resume = 1'b0;
    resume_se0 = 1'b0;
    resume_k   = 1'b0;
    if (ctrl_ff[phy_ctrl_pkg::SUSP_EN_BIT] && susp_ff && filt_change) begin
      resume_se0 = (filt_state == phy_ctrl_pkg::LS_SE0);
      resume_k   = (filt_state == phy_ctrl_pkg::LS_K);
      nxt_resume = resume_se0 || resume_k;
    end
    if (wr_hit) begin
      if (avs_address == phy_ctrl_pkg::PHY_CONTROL_ADDR) begin
        nxt_ctrl = merge_bytes(ctrl_ff, avs_writedata, avs_byteenable)
                   & phy_ctrl_pkg::PHY_CONTROL_WMASK;
      end else if (avs_address == phy_ctrl_pkg::IRQ_ENABLE_ADDR) begin
        nxt_ien = avs_writedata[phy_ctrl_pkg::IRQ_W-1:0];
      end else if (avs_address == phy_ctrl_pkg::IRQ_CLEAR_ADDR) begin
        nxt_sts = sts_ff & ~avs_writedata[phy_ctrl_pkg::IRQ_W-1:0];
      end
    end
    // Hardware sets land after software writes, so an event in a clear cycle is kept.
    // Capture SE0 cause.
    if (resume_se0) begin
      nxt_ctrl[phy_ctrl_pkg::RST_CAUSE_BIT] = 1'b1;
      nxt_sts[phy_ctrl_pkg::IRQ_RST_CAUSE]  = 1'b1;
    end
    if (resume_k) begin
      nxt_ctrl[phy_ctrl_pkg::RES_CAUSE_BIT] = 1'b1;
      nxt_sts[phy_ctrl_pkg::IRQ_RES_CAUSE]  = 1'b1;
    end
    if (filt_change) begin
      nxt_sts[phy_ctrl_pkg::IRQ_LINE_CHG] = 1'b1;
    end
    nxt_irq   = |(nxt_sts & nxt_ien);
    nxt_pd    = ~nxt_ctrl[phy_ctrl_pkg::PD_DIS_BIT];
    nxt_strap = nxt_ctrl[phy_ctrl_pkg::CONF_LSB +: phy_ctrl_pkg::CONF_W];
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_ff   <= phy_ctrl_pkg::PHY_CONTROL_RST;
      sts_ff    <= '0;
      ien_ff    <= '0;
      irq_ff    <= 1'b0;
      pd_ff     <= 1'b1;
      strap_ff  <= 3'h0;
      resume_ff <= 1'b0;
      susp_ff   <= 1'b0;
    end else begin
      ctrl_ff   <= nxt_ctrl;
      sts_ff    <= nxt_sts;
      ien_ff    <= nxt_ien;
      irq_ff    <= nxt_irq;
      pd_ff     <= nxt_pd;
      strap_ff  <= nxt_strap;
      resume_ff <= nxt_resume;
      susp_ff   <= nxt_susp;
    end
  end

  assign avs_readdata      = rdata_ff;
  assign avs_waitrequest   = wait_ff;
  assign wide_port_a_pd_en = pd_ff;
  assign wide_port_b_pd_en = pd_ff;
  assign phy_strap_inputs  = strap_ff;
  assign auto_resume       = resume_ff;
  assign irq               = irq_ff;
endmodule

/* File: verif/usb_phy_checker.sv */
// Concurrent checks on the PHY control block ports.
// Assumes it is bound to usb_phy_control_resume on core_clk.
`timescale 1ns/1ns
module usb_phy_checker (
  input wire logic        core_clk,
  input wire logic        rstn,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        wide_port_a_pd_en,
  input wire logic        wide_port_b_pd_en,
  input wire logic [2:0]  phy_strap_inputs,
  input wire logic        auto_resume
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  logic ctl_wr;
  logic ctl_rd;
  assign ctl_wr = avs_write && !avs_waitrequest
                  && avs_address == phy_ctrl_pkg::PHY_CONTROL_ADDR;
  assign ctl_rd = avs_read && !avs_waitrequest
                  && avs_address == phy_ctrl_pkg::PHY_CONTROL_ADDR;
  chk_pd_pair: assert property (wide_port_a_pd_en == wide_port_b_pd_en)
    else $error("pull-down enables differ");
  chk_pd_follow: assert property (
    ctl_wr && avs_byteenable[2]
    |=> wide_port_a_pd_en == !$past(avs_writedata[phy_ctrl_pkg::PD_DIS_BIT]))
    else $error("pull-down enable misses write");
  chk_strap_set: assert property (
    ctl_wr && avs_byteenable[0]
    |=> phy_strap_inputs == $past(avs_writedata[phy_ctrl_pkg::CONF_LSB +: phy_ctrl_pkg::CONF_W]))
    else $error("strap pins miss write");
  chk_strap_hold: assert property (!ctl_wr [*3] |-> $stable(phy_strap_inputs))
    else $error("strap pins moved without write");
  chk_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("answer not after one wait state");
  chk_wait_short: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  chk_rsvd_zero: assert property (
    ctl_rd |-> (avs_readdata & ~phy_ctrl_pkg::PHY_CONTROL_WMASK) == 32'h0000_0000)
    else $error("reserved control bits read nonzero");
  chk_res_pulse: assert property (auto_resume |=> !auto_resume)
    else $error("resume pulse longer than one cycle");
  cover property (auto_resume);
  cover property (ctl_wr);
  cover property (ctl_rd);
endmodule
bind usb_phy_control_resume usb_phy_checker usb_phy_checker_inst (.core_clk, .rstn, .avs_address,
  .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
  .wide_port_a_pd_en, .wide_port_b_pd_en, .phy_strap_inputs, .auto_resume);

/* File: verif/phy_line_model.sv */
// Line-state and suspend model of the USB transceiver.
// Assumes the bench sets the wanted levels on rising edges.
`timescale 1ns/1ns
module phy_line_model (
  input  wire logic       core_clk,
  input  wire logic [1:0] want,
  input  wire logic       want_susp,
  output logic      [1:0] line_state = 2'h1,
  output logic            suspended = 1'b0
);
  // Pins move on the falling edge, so they stay out of phase with the core clock.
  always @(negedge core_clk) begin
    line_state <= want;
    suspended <= want_susp;
  end
endmodule

/* File: verif/usb_phy_control_resume_tb.sv */
// Self-checking bench for usb_phy_control_resume.
// Assumes the bound checker and the line-state model beside the design.
`timescale 1ns/1ns
module usb_phy_control_resume_tb;
  logic        core_clk = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_readdata, ctl, q[$];
  logic [31:0] seed = 32'h0000_8048;
  logic        avs_waitrequest, pd_a, pd_b, auto_resume, irq, susp, seen;
  logic        want_susp = 1'b0;
  logic [2:0]  strap;
  logic [1:0]  line;
  logic [1:0]  want = 2'h1;
  int          miscompares = 0;
  int          cmp_count = 0;
  always #4 core_clk = ~core_clk;
  usb_phy_control_resume usb_phy_control_resume_inst (.core_clk(core_clk), .rstn(rstn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .phy_line_state(line),
    .phy_suspended(susp), .wide_port_a_pd_en(pd_a), .wide_port_b_pd_en(pd_b),
    .phy_strap_inputs(strap), .auto_resume(auto_resume), .irq(irq));
  phy_line_model phy_line_model_inst (.core_clk(core_clk), .want(want), .want_susp(want_susp),
    .line_state(line), .suspended(susp));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Reads leave their expected word in the queue for the monitor.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    if (!w) q.push_back(d);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= w ? d : 32'h0000_0000;
    @(posedge core_clk iff !avs_waitrequest);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask
  task automatic wait_res(input int n);
    seen = 1'b0;
    repeat (n) begin
      @(posedge core_clk);
      if (auto_resume === 1'b1) seen = 1'b1;
    end
  endtask
  task automatic test_done();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    if (avs_read && !avs_waitrequest && q.size() > 0) begin
      chk(avs_readdata, q.pop_front());
    end
  end
  initial begin
    repeat (5000) @(posedge core_clk);
    miscompares++;
    test_done();
  end
  initial begin
    repeat (10) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    chk(32'({pd_a, pd_b, strap}), 32'h0000_0018);
    bus(1'b0, phy_ctrl_pkg::PHY_CONTROL_ADDR, 32'h0000_0000);
    seed = lfsr(seed);
    ctl = 32'h0004_0480 | {25'h0, seed[2:0], 4'h0};
    bus(1'b1, phy_ctrl_pkg::PHY_CONTROL_ADDR, ctl | (seed & ~phy_ctrl_pkg::PHY_CONTROL_WMASK));
    chk(32'({pd_a, pd_b, strap}), {29'h0, seed[2:0]});
    bus(1'b0, phy_ctrl_pkg::PHY_CONTROL_ADDR, ctl);
    bus(1'b1, phy_ctrl_pkg::IRQ_ENABLE_ADDR, 32'h0000_0007);
    want_susp <= 1'b1;
    want <= phy_ctrl_pkg::LS_K;
    repeat (3) @(posedge core_clk);
    want <= phy_ctrl_pkg::LS_J;
    wait_res(30);
    chk(32'(seen), 32'h0000_0000);
    want <= phy_ctrl_pkg::LS_K;
    repeat (4) @(posedge core_clk);
    bus(1'b0, phy_ctrl_pkg::LINE_STATE_ADDR, 32'h0000_0009);
    wait_res(60);
    chk(32'({seen, irq}), 32'h0000_0003);
    bus(1'b0, phy_ctrl_pkg::PHY_CONTROL_ADDR, ctl | 32'h0000_1000);
    bus(1'b0, phy_ctrl_pkg::IRQ_STATUS_ADDR, 32'h0000_0006);
    bus(1'b1, phy_ctrl_pkg::IRQ_CLEAR_ADDR, 32'h0000_0007);
    chk(32'(irq), 32'h0000_0000);
    bus(1'b1, phy_ctrl_pkg::PHY_CONTROL_ADDR, ctl);
    want <= phy_ctrl_pkg::LS_SE0;
    wait_res(60);
    chk(32'(seen), 32'h0000_0001);
    bus(1'b0, phy_ctrl_pkg::PHY_CONTROL_ADDR, ctl | 32'h0000_2000);
    // With suspend enable cleared nothing may resume; only the line-change status still raises irq.
    bus(1'b1, phy_ctrl_pkg::PHY_CONTROL_ADDR, ctl & ~32'h0000_0080);
    want <= phy_ctrl_pkg::LS_J;
    wait_res(40);
    want <= phy_ctrl_pkg::LS_SE0;
    wait_res(60);
    chk(32'(seen), 32'h0000_0000);
    bus(1'b0, phy_ctrl_pkg::PHY_CONTROL_ADDR, ctl & ~32'h0000_0080);
    bus(1'b0, 8'h10, 32'h0000_0000);
    chk(32'(q.size()), 32'h0000_0000);
    test_done();
  end
endmodule
